// *** hw/fault_autorestart.sv ***
module fault_autorestart #(
	parameter int TICK_CYCLES       = fault_pkg::TICK_CYCLES,
	parameter int RESTART_TICKS     = fault_pkg::RESTART_TICKS,
	parameter int DIS_RESTART_TICKS = fault_pkg::DIS_RESTART_TICKS,
	parameter int LONG_OVL_TICKS    = fault_pkg::LONG_OVL_TICKS,
	parameter int OVL_END_CYCLES    = fault_pkg::OVL_END_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        osc_cycle_end,
	input  wire logic        overcurrent_comparator,
	input  wire logic        max_duty_end,
	input  wire logic        minimum_skip_frequency,
	input  wire logic        clamp_overcurrent,
	input  wire logic        shutdown_input,
	input  wire logic        thermal_flag,
	output logic             pwm_enable,
	output logic       [3:0] current_limit_step
);
	localparam int TW = 22;
	localparam int CW = 15;

	fault_pkg::fault_in_t raw;
	fault_pkg::fault_in_t sync1;
	fault_pkg::fault_in_t sync2;
	logic                 cycle_d;
	fault_pkg::state_t    state;
	fault_pkg::state_t    next_state;
	fault_pkg::cause_t    cause;
	logic [2:0]           ctrl;
	logic [7:0]           tick_cnt;
	logic                 tick;
	logic [CW-1:0]        ovl_count;
	logic [TW-1:0]        long_cnt;
	logic [3:0]           maxd_count;
	logic [TW-1:0]        clamp_cnt;
	logic [TW-1:0]        dis_cnt;
	logic                 dis_filt;
	logic [TW-1:0]        ss_cnt;
	logic [3:0]           ss_step;
	logic                 temp_pending;
	logic                 rst_busy;
	logic                 dis_busy;
	logic                 cycle;
	logic                 run_ok;
	logic                 soft_active;
	logic                 ovl_trip;
	logic                 long_trip;
	logic                 maxd_trip;
	logic                 clamp_trip;
	logic                 dis_trip;
	logic                 temp_trip;
	logic                 probe_hot;
	logic                 load_rst;
	logic                 apb_done;
	logic [31:0]          rd_value;

	generate
		if (TICK_CYCLES < 1 || TICK_CYCLES > 255 || OVL_END_CYCLES < 1
			|| (OVL_END_CYCLES << 2) >= (1 << CW) || RESTART_TICKS >= (1 << TW)
			|| (LONG_OVL_TICKS << 2) >= (1 << TW) || DIS_RESTART_TICKS >= (1 << TW))
		begin : g_chk
			$error("fault_autorestart parameters out of range");
		end
	endgenerate

	// Scales a base count by the switching frequency option.
	function automatic logic [TW-1:0] scale(input int base, input logic [1:0] opt);
		logic [1:0] s;
		s = (opt == 2'd3) ? 2'd2 : opt;
		scale = TW'(base) << s;
	endfunction

	assign raw = '{osc_cycle_end, overcurrent_comparator, max_duty_end,
		minimum_skip_frequency, clamp_overcurrent, shutdown_input, thermal_flag};

	// Brings every comparator flag into the clock domain.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1   <= '0;
			sync2   <= '0;
			cycle_d <= 1'b0;
		end
		else
		begin
			sync1   <= raw;
			sync2   <= sync1;
			cycle_d <= sync2.cycle_end;
		end
	end

	assign cycle       = sync2.cycle_end && !cycle_d;
	assign run_ok      = (state == fault_pkg::ST_RUN) && ctrl[fault_pkg::CTRL_EN_BIT];
	assign soft_active = ss_step != 4'(fault_pkg::SS_STEPS);

	// Fixed time base that every millisecond and second timer except the overload delay counts.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= (tick_cnt == 8'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 8'(TICK_CYCLES - 1)) ? 8'h00 : tick_cnt + 8'h01;
		end
	end

	assign ovl_trip   = run_ok && cycle && sync2.overcurrent_comparator
		&& (ovl_count == CW'(scale(OVL_END_CYCLES, ctrl[2:1]) - TW'(1)));
	assign long_trip  = run_ok && tick && sync2.minimum_skip_frequency
		&& (long_cnt == scale(LONG_OVL_TICKS, ctrl[2:1]) - TW'(1));
	assign maxd_trip  = run_ok && cycle && sync2.max_duty_end
		&& (maxd_count == 4'(fault_pkg::MAXD_CYCLES - 1));
	assign clamp_trip = run_ok && !soft_active && tick && sync2.clamp_overcurrent
		&& (clamp_cnt == TW'(fault_pkg::CLAMP_TICKS));
	assign dis_trip   = dis_filt && tick && sync2.shutdown_input && !dis_busy
		&& (dis_cnt == TW'(fault_pkg::DIS_FILTER_TICKS - 1));
	assign temp_trip  = run_ok && sync2.thermal_flag;
	assign probe_hot  = (state == fault_pkg::ST_PROBE) && cycle && sync2.thermal_flag;
	assign load_rst   = ovl_trip || long_trip || maxd_trip || clamp_trip
		|| temp_trip || probe_hot;

	// Up/down overload counter, one step per switching cycle.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			ovl_count <= '0;
		else if (ovl_trip || !run_ok)
			ovl_count <= '0;
		else if (cycle && sync2.overcurrent_comparator)
			ovl_count <= ovl_count + CW'(1);
		else if (cycle && ovl_count != '0)
			ovl_count <= ovl_count - CW'(1);
	end

	// Time spent continuously pinned at the minimum skip frequency.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			long_cnt <= '0;
		else if (!run_ok || !sync2.minimum_skip_frequency || long_trip)
			long_cnt <= '0;
		else if (tick)
			long_cnt <= long_cnt + TW'(1);
	end

	// Consecutive cycles ended by the maximum duty limit.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			maxd_count <= '0;
		else if (!run_ok || maxd_trip)
			maxd_count <= '0;
		else if (cycle)
			maxd_count <= sync2.max_duty_end ? maxd_count + 4'h1 : 4'h0;
	end

	// Clamp overcurrent duration, held at zero during soft-start.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			clamp_cnt <= '0;
		else if (!run_ok || soft_active || !sync2.clamp_overcurrent || clamp_trip)
			clamp_cnt <= '0;
		else if (tick)
			clamp_cnt <= clamp_cnt + TW'(1);
	end

	// Shutdown filter runs its full time once started.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			dis_filt <= 1'b0;
			dis_cnt  <= '0;
		end
		else if (!dis_filt)
		begin
			dis_filt <= sync2.shutdown_input && !dis_busy;
			dis_cnt  <= '0;
		end
		else if (tick)
		begin
			dis_filt <= (dis_cnt != TW'(fault_pkg::DIS_FILTER_TICKS - 1));
			dis_cnt  <= dis_cnt + TW'(1);
		end
	end

	interval_timer #(.WIDTH(TW)) u_restart (
		.mclk   (mclk),
		.resetn (resetn),
		.load   (load_rst),
		.tick   (tick),
		.count  (TW'(RESTART_TICKS)),
		.busy   (rst_busy)
	);

	interval_timer #(.WIDTH(TW)) u_dis_restart (
		.mclk   (mclk),
		.resetn (resetn),
		.load   (dis_trip),
		.tick   (tick),
		.count  (TW'(DIS_RESTART_TICKS)),
		.busy   (dis_busy)
	);

	// Chooses between switching, waiting out restart intervals and probing.
	always_comb
	begin
		next_state = state;
		case (state)
			fault_pkg::ST_RUN:
				if (load_rst || dis_trip)
					next_state = fault_pkg::ST_OFF;
			fault_pkg::ST_OFF:
				if (!rst_busy && !dis_busy && !load_rst && !dis_trip)
					next_state = temp_pending ? fault_pkg::ST_PROBE : fault_pkg::ST_RUN;
			fault_pkg::ST_PROBE:
				if (probe_hot || dis_trip)
					next_state = fault_pkg::ST_OFF;
				else if (cycle)
					next_state = fault_pkg::ST_RUN;
			default:
				next_state = fault_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state      <= fault_pkg::ST_RUN;
			pwm_enable <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			pwm_enable <= ctrl[fault_pkg::CTRL_EN_BIT]
				&& (next_state != fault_pkg::ST_OFF);
		end
	end

	// Remembers an over-temperature trip until a probe cycle finds it cool.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			temp_pending <= 1'b0;
		else if (temp_trip || probe_hot)
			temp_pending <= 1'b1;
		else if ((state == fault_pkg::ST_PROBE) && cycle)
			temp_pending <= 1'b0;
	end

	// Soft-start ramp restarted from zero whenever switching is not running.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ss_step <= '0;
			ss_cnt  <= '0;
		end
		else if (!run_ok)
		begin
			ss_step <= '0;
			ss_cnt  <= '0;
		end
		else if (tick && soft_active)
		begin
			ss_cnt <= (ss_cnt == TW'(fault_pkg::SS_STEP_TICKS - 1)) ? '0 : ss_cnt + TW'(1);
			if (ss_cnt == TW'(fault_pkg::SS_STEP_TICKS - 1))
				ss_step <= ss_step + 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			current_limit_step <= '0;
		else
			current_limit_step <= (next_state == fault_pkg::ST_PROBE)
				? 4'(fault_pkg::SS_STEPS) : ss_step;
	end

	assign apb_done = psel && penable && pready;

	// Sticky trip causes; a new trip in the clearing cycle stays set.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			cause <= '0;
		else
			cause <= (cause & ~((apb_done && pwrite && paddr == fault_pkg::ADDR_STATUS)
				? pwdata[fault_pkg::STAT_CAUSE_LSB +: 5] : 5'h00))
				| {ovl_trip || long_trip, maxd_trip, clamp_trip, dis_trip,
				temp_trip || probe_hot};
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			ctrl <= fault_pkg::CTRL_RESET;
		else if (apb_done && pwrite && paddr == fault_pkg::ADDR_CTRL)
			ctrl <= pwdata[2:0];
	end

	always_comb
	begin
		rd_value = 32'h0000_0000;
		case (paddr)
			fault_pkg::ADDR_CTRL:
				rd_value[2:0] = ctrl;
			fault_pkg::ADDR_STATUS:
			begin
				rd_value[fault_pkg::STAT_PWM_BIT]       = pwm_enable;
				rd_value[fault_pkg::STAT_SS_BIT]        = soft_active && run_ok;
				rd_value[fault_pkg::STAT_RST_BIT]       = rst_busy;
				rd_value[fault_pkg::STAT_DIS_BIT]       = dis_busy;
				rd_value[fault_pkg::STAT_STEP_LSB +: 4] = current_limit_step;
				rd_value[fault_pkg::STAT_CAUSE_LSB +: 5] = cause;
			end
			fault_pkg::ADDR_OVLCNT:
				rd_value[CW-1:0] = ovl_count;
			default:
				rd_value = 32'h0000_0000;
		endcase
	end

	// APB slave answering one cycle into the access phase.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite) ? rd_value : 32'h0000_0000;
			pslverr <= psel && penable && !pready && paddr != fault_pkg::ADDR_CTRL
				&& paddr != fault_pkg::ADDR_STATUS && paddr != fault_pkg::ADDR_OVLCNT;
		end
	end

	a_ovl_trip_off: assert property (@(posedge mclk) disable iff (!resetn)
		ovl_trip |=> !pwm_enable && state == fault_pkg::ST_OFF)
		else $error("overload trip did not stop switching");
	a_ovl_count_up: assert property (@(posedge mclk) disable iff (!resetn)
		run_ok && cycle && sync2.overcurrent_comparator && !ovl_trip
		|=> ovl_count == $past(ovl_count) + CW'(1))
		else $error("overload count did not rise");
	a_ovl_count_down: assert property (@(posedge mclk) disable iff (!resetn)
		run_ok && cycle && !sync2.overcurrent_comparator && ovl_count != '0
		|=> ovl_count == $past(ovl_count) - CW'(1))
		else $error("overload count did not fall");
	a_maxd_trip_off: assert property (@(posedge mclk) disable iff (!resetn)
		maxd_trip |=> !pwm_enable ##1 rst_busy)
		else $error("max duty trip did not stop switching");
	a_restart_hold: assert property (@(posedge mclk) disable iff (!resetn)
		(rst_busy || dis_busy) |-> state == fault_pkg::ST_OFF && !pwm_enable)
		else $error("switching during restart interval");
	a_ss_from_zero: assert property (@(posedge mclk) disable iff (!resetn)
		$past(state) == fault_pkg::ST_OFF && state == fault_pkg::ST_RUN
		|-> ss_step == 4'h0)
		else $error("restart without fresh soft-start");
	a_clamp_ignored: assert property (@(posedge mclk) disable iff (!resetn)
		soft_active |-> !clamp_trip)
		else $error("clamp trip during soft-start");
	a_dis_filter: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(dis_busy) |-> $past(sync2.shutdown_input) && $past(dis_filt))
		else $error("shutdown trip without filtered condition");
	a_probe_one: assert property (@(posedge mclk) disable iff (!resetn)
		state == fault_pkg::ST_PROBE && cycle |=> state != fault_pkg::ST_PROBE)
		else $error("probe lasted more than one cycle");

	c_ovl_trip: cover property (@(posedge mclk) disable iff (!resetn) ovl_trip);
	c_dis_trip: cover property (@(posedge mclk) disable iff (!resetn) dis_trip);
	c_probe: cover property (@(posedge mclk) disable iff (!resetn)
		state == fault_pkg::ST_PROBE ##1 state == fault_pkg::ST_RUN);
	c_ss_done: cover property (@(posedge mclk) disable iff (!resetn) $fell(soft_active));
endmodule

// *** hw/fault_pkg.sv ***
package fault_pkg;
	localparam int CLK_PERIOD_NS      = 5;
	localparam int TICK_PERIOD_NS     = 1000;
	localparam int TICK_CYCLES        = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICKS_PER_MS       = 1000000 / TICK_PERIOD_NS;
	localparam int OVL_DELAY_MS       = 50;
	localparam int BASE_FSW_KHZ       = 30;
	localparam int OVL_END_CYCLES     = OVL_DELAY_MS * BASE_FSW_KHZ;
	localparam int MIN_SKIP_KHZ       = 15;
	localparam int LONG_OVL_MS        = 100;
	localparam int LONG_OVL_TICKS     = LONG_OVL_MS * TICKS_PER_MS;
	localparam int RESTART_MS         = 1000;
	localparam int RESTART_TICKS      = RESTART_MS * TICKS_PER_MS;
	localparam int DIS_RESTART_MS     = 500;
	localparam int DIS_RESTART_TICKS  = DIS_RESTART_MS * TICKS_PER_MS;
	localparam int DIS_FILTER_MS      = 1;
	localparam int DIS_FILTER_TICKS   = DIS_FILTER_MS * TICKS_PER_MS;
	localparam int CLAMP_US           = 500;
	localparam int CLAMP_TICKS        = CLAMP_US * 1000 / TICK_PERIOD_NS;
	localparam int SS_STEPS           = 8;
	localparam int SS_TIME_MS         = 8;
	localparam int SS_STEP_TICKS      = SS_TIME_MS * TICKS_PER_MS / SS_STEPS;
	localparam int MAXD_CYCLES        = 10;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_OVLCNT = 12'h008;
	localparam int CTRL_EN_BIT        = 0;
	localparam int CTRL_OPT_LSB       = 1;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	localparam int STAT_PWM_BIT       = 0;
	localparam int STAT_SS_BIT        = 1;
	localparam int STAT_RST_BIT       = 2;
	localparam int STAT_DIS_BIT       = 3;
	localparam int STAT_STEP_LSB      = 4;
	localparam int STAT_CAUSE_LSB     = 8;
	typedef struct packed {
		logic cycle_end;
		logic overcurrent_comparator;
		logic max_duty_end;
		logic minimum_skip_frequency;
		logic clamp_overcurrent;
		logic shutdown_input;
		logic thermal_flag;
	} fault_in_t;
	typedef struct packed {
		logic overload;
		logic max_duty;
		logic clamp;
		logic shutdown;
		logic thermal;
	} cause_t;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_OFF   = 3'b010,
		ST_PROBE = 3'b100
	} state_t;
endpackage

// *** hw/interval_timer.sv ***
module interval_timer #(
	parameter int WIDTH = 20
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             load,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] count,
	output logic                  busy
);
	logic [WIDTH-1:0] remaining;

	generate
		if (WIDTH < 2)
		begin : g_chk
			$error("interval_timer width too small");
		end
	endgenerate

	// Counts the loaded number of time-base ticks down to zero.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			remaining <= '0;
			busy      <= 1'b0;
		end
		else if (load)
		begin
			remaining <= count;
			busy      <= (count != '0);
		end
		else if (tick && busy)
		begin
			remaining <= remaining - WIDTH'(1);
			busy      <= (remaining != WIDTH'(1));
		end
	end
endmodule

// *** tb/switch_model.sv ***
module switch_model #(
	parameter int PERIOD = 24
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic pwm_enable,
	input  wire logic oc_cmd,
	input  wire logic md_cmd,
	output logic      osc_cycle_end,
	output logic      overcurrent_comparator,
	output logic      max_duty_end
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// The oscillator runs free and marks each cycle end with a two-clock pulse.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 0;
			osc_cycle_end <= 1'h0;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			osc_cycle_end <= (cnt == PERIOD - 1) || (cnt == 0);
		end
	end
	// Flags move mid-cycle only, so they are steady at every cycle end.
	// A gate that is held off ends no cycle by current or by duty.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			overcurrent_comparator <= 1'h0;
			max_duty_end <= 1'h0;
		end
		else if (cnt == PERIOD / 2)
		begin
			overcurrent_comparator <= oc_cmd & pwm_enable;
			max_duty_end <= md_cmd & pwm_enable;
		end
	end
endmodule

// *** tb/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'h0;
	logic        resetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc_cycle_end;
	logic        overcurrent_comparator;
	logic        max_duty_end;
	logic        minimum_skip_frequency = 1'h0;
	logic        clamp_overcurrent = 1'h0;
	logic        shutdown_input = 1'h0;
	logic        thermal_flag = 1'h0;
	logic        oc_cmd = 1'h0;
	logic        md_cmd = 1'h0;
	logic        pwm_enable;
	logic [3:0]  current_limit_step;
	logic [31:0] q;
	logic        er;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	localparam logic [11:0] A_C = fault_pkg::ADDR_CTRL;
	localparam logic [11:0] A_S = fault_pkg::ADDR_STATUS;
	localparam logic [11:0] A_O = fault_pkg::ADDR_OVLCNT;
	always #2.5 mclk = ~mclk;
	fault_autorestart #(.TICK_CYCLES(2), .RESTART_TICKS(50), .DIS_RESTART_TICKS(25),
		.LONG_OVL_TICKS(20), .OVL_END_CYCLES(5)) fault_autorestart_i (
		.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .osc_cycle_end, .overcurrent_comparator, .max_duty_end,
		.minimum_skip_frequency, .clamp_overcurrent, .shutdown_input, .thermal_flag,
		.pwm_enable, .current_limit_step);
	switch_model switch_model_i (.mclk, .resetn, .pwm_enable, .oc_cmd, .md_cmd,
		.osc_cycle_end, .overcurrent_comparator, .max_duty_end);
	task automatic final_report();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
		begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		q = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk(n < 50, 1'h1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(q & m, e);
		chk(er, 1'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		chk(er, 1'h0);
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge osc_cycle_end);
		repeat (8) @(posedge mclk);
	endtask
	task automatic clk_n(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic pwm_at(input logic v, input int lo, input int hi);
		int t;
		t = 0;
		while (pwm_enable !== v && t < hi)
		begin
			@(posedge mclk);
			t++;
		end
		chk(pwm_enable, v);
		chk(t >= lo, 1'h1);
	endtask
	initial
	begin
		int t;
		clk_n(5);
		resetn <= 1'h1;
		chk(pwm_enable, 1'h0);
		chk(current_limit_step, 4'h0);
		clk_n(2);
		chk(pwm_enable, 1'h1);
		rd(A_C, 32'hFFFF_FFFF, 32'h0000_0001);
		rd(A_O, 32'h0000_7FFF, 32'h0000_0000);
		apb(1'h0, 12'h00C, 32'h0000_0000);
		chk(er, 1'h1);
		chk(q, 32'h0000_0000);
		cyc_n(1);
		oc_cmd <= 1'h1;
		cyc_n(3);
		oc_cmd <= 1'h0;
		rd(A_O, 32'h0000_7FFF, 32'h0000_0003);
		cyc_n(1);
		rd(A_O, 32'h0000_7FFF, 32'h0000_0002);
		cyc_n(3);
		oc_cmd <= 1'h1;
		rd(A_O, 32'h0000_7FFF, 32'h0000_0000);
		cyc_n(4);
		chk(pwm_enable, 1'h1);
		cyc_n(1);
		oc_cmd <= 1'h0;
		chk(pwm_enable, 1'h0);
		rd(A_S, 32'h0000_1004, 32'h0000_1004);
		pwm_at(1'h1, 70, 130);
		chk(current_limit_step, 4'h0);
		clamp_overcurrent <= 1'h1;
		clk_n(1200);
		clamp_overcurrent <= 1'h0;
		chk(pwm_enable, 1'h1);
		chk(current_limit_step, 4'h0);
		clk_n(1800);
		chk(current_limit_step, 4'h1);
		for (t = 0; current_limit_step !== 4'h8 && t < 14000; t++)
			@(posedge mclk);
		chk(t > 12000, 1'h1);
		chk(current_limit_step, 4'h8);
		clamp_overcurrent <= 1'h1;
		clk_n(900);
		chk(pwm_enable, 1'h1);
		clk_n(130);
		clamp_overcurrent <= 1'h0;
		chk(pwm_enable, 1'h0);
		pwm_at(1'h1, 60, 130);
		rd(A_S, 32'h0000_1F00, 32'h0000_1400);
		wr(A_S, 32'h0000_1F00);
		cyc_n(1);
		md_cmd <= 1'h1;
		cyc_n(9);
		md_cmd <= 1'h0;
		chk(pwm_enable, 1'h1);
		cyc_n(1);
		md_cmd <= 1'h1;
		cyc_n(9);
		chk(pwm_enable, 1'h1);
		cyc_n(1);
		chk(pwm_enable, 1'h0);
		pwm_at(1'h1, 70, 130);
		pwm_at(1'h0, 216, 304);
		md_cmd <= 1'h0;
		pwm_at(1'h1, 80, 130);
		rd(A_S, 32'h0000_1F00, 32'h0000_0800);
		shutdown_input <= 1'h1;
		clk_n(1000);
		shutdown_input <= 1'h0;
		clk_n(2000);
		chk(pwm_enable, 1'h1);
		shutdown_input <= 1'h1;
		pwm_at(1'h0, 1980, 2040);
		rd(A_S, 32'h0000_000C, 32'h0000_0008);
		shutdown_input <= 1'h0;
		pwm_at(1'h1, 30, 70);
		thermal_flag <= 1'h1;
		clk_n(10);
		chk(pwm_enable, 1'h0);
		pwm_at(1'h1, 80, 130);
		chk(current_limit_step, 4'h8);
		pwm_at(1'h0, 1, 60);
		thermal_flag <= 1'h0;
		pwm_at(1'h1, 80, 130);
		chk(current_limit_step, 4'h8);
		clk_n(60);
		chk(pwm_enable, 1'h1);
		chk(current_limit_step, 4'h0);
		wr(A_C, 32'h0000_0003);
		rd(A_C, 32'h0000_0007, 32'h0000_0003);
		minimum_skip_frequency <= 1'h1;
		pwm_at(1'h0, 70, 100);
		minimum_skip_frequency <= 1'h0;
		pwm_at(1'h1, 70, 130);
		wr(A_C, 32'h0000_0000);
		clk_n(4);
		chk(pwm_enable, 1'h0);
		wr(A_C, 32'h0000_0001);
		clk_n(4);
		chk(pwm_enable, 1'h1);
		resetn <= 1'h0;
		clk_n(2);
		chk(pwm_enable, 1'h0);
		resetn <= 1'h1;
		rd(A_S, 32'h0000_1F00, 32'h0000_0000);
		rd(A_O, 32'h0000_7FFF, 32'h0000_0000);
		final_report();
	end
endmodule
